/* hdl/ima_pkg.sv */
/*
 * Package for the memory-mapped access front end of the interrupt controller:
 * group codes, register offsets, reset values, access kinds and decode functions.
 * Assumes a byte address of 16 bits whose top nibble selects the register group.
 */
package ima_pkg;

	// ----------------------------------------------------------------
	// address layout
	// ----------------------------------------------------------------
	localparam int          ADDR_W   = 16;
	localparam int          DATA_W   = 64;
	localparam logic [3:0]  GRP_CPU  = 4'h0;
	localparam logic [3:0]  GRP_VIRT = 4'h1;
	localparam logic [3:0]  GRP_DIST = 4'h2;
	localparam logic [3:0]  GRP_HYP  = 4'h3;
	localparam logic [3:0]  GRP_ITS  = 4'h4;
	localparam logic [3:0]  GRP_RDIST = 4'h5;

	localparam logic [11:0] OFF_CTL       = 12'h000;
	localparam logic [11:0] OFF_PMK       = 12'h004;
	localparam logic [11:0] OFF_BPT       = 12'h008;
	localparam logic [11:0] OFF_ABPT      = 12'h00C;
	localparam logic [11:0] OFF_AP0       = 12'h010;
	localparam logic [11:0] OFF_AP1NS     = 12'h014;
	localparam logic [11:0] OFF_DTYPE     = 12'h004;
	localparam logic [11:0] OFF_SWSET     = 12'h040;
	localparam logic [11:0] OFF_SWCLR     = 12'h044;
	localparam logic [11:0] OFF_PRIO      = 12'h100;
	localparam logic [11:0] OFF_TARGET    = 12'h200;
	localparam logic [11:0] OFF_W64       = 12'h300;
	localparam logic [11:0] OFF_W64ONLY   = 12'h308;
	localparam logic [11:0] OFF_DB_NS_SET = 12'h400;
	localparam logic [11:0] OFF_DB_NS_CLR = 12'h404;
	localparam logic [11:0] OFF_DB_S_SET  = 12'h408;
	localparam logic [11:0] OFF_DB_S_CLR  = 12'h40C;
	localparam logic [11:0] OFF_ITS_BASE  = 12'h000;
	localparam logic [11:0] OFF_ITS_DB    = 12'h040;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          CTL_CBPT_BIT = 0;
	localparam int          BPT_W        = 3;
	localparam int          SH_CTL   = 0;
	localparam int          SH_PMK   = 1;
	localparam int          SH_BPT   = 2;
	localparam int          SH_ABPT  = 3;
	localparam int          SH_AP0   = 4;
	localparam int          SH_AP1NS = 5;
	localparam int          SH_N     = 6;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [63:0] RST_DWORD = 64'h0000_0000_0000_0000;
	localparam logic [7:0]  RST_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD, SZ_QUAD} ima_size_t;
	typedef enum logic [2:0] {K_NONE, K_W32, K_W64, K_W64ONLY, K_BYTEARR, K_DOORBELL} ima_kind_t;
	typedef enum logic [1:0] {ACC_RW, ACC_RO, ACC_WO} ima_acc_t;
	typedef enum logic [4:0] {
		R_NONE, R_CPU_CTL, R_CPU_PMK, R_CPU_BPT, R_CPU_ABPT, R_CPU_AP0, R_CPU_AP1NS,
		R_VIRT_PMK, R_HYP_CTL, R_DIST_CTL, R_DIST_TYPE, R_SWSET, R_SWCLR, R_PRIO,
		R_RPRIO, R_TARGET, R_DIST_W64, R_DIST_W64ONLY, R_DB_NS_SET, R_DB_NS_CLR,
		R_DB_S_SET, R_DB_S_CLR, R_ITS_BASE, R_ITS_DB, R_RDIST_W64
	} ima_reg_t;

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	function automatic ima_reg_t reg_lookup(input logic [3:0] grp, input logic [11:0] off);
		reg_lookup = R_NONE;
		case (grp)
		GRP_CPU: begin
			if (off[11:2] == OFF_CTL[11:2]) reg_lookup = R_CPU_CTL;
			if (off[11:2] == OFF_PMK[11:2]) reg_lookup = R_CPU_PMK;
			if (off[11:2] == OFF_BPT[11:2]) reg_lookup = R_CPU_BPT;
			if (off[11:2] == OFF_ABPT[11:2]) reg_lookup = R_CPU_ABPT;
			if (off[11:2] == OFF_AP0[11:2]) reg_lookup = R_CPU_AP0;
			if (off[11:2] == OFF_AP1NS[11:2]) reg_lookup = R_CPU_AP1NS;
		end
		GRP_VIRT: if (off[11:2] == OFF_PMK[11:2]) reg_lookup = R_VIRT_PMK;
		GRP_HYP: if (off[11:2] == OFF_CTL[11:2]) reg_lookup = R_HYP_CTL;
		GRP_DIST: begin
			if (off[11:2] == OFF_CTL[11:2]) reg_lookup = R_DIST_CTL;
			if (off[11:2] == OFF_DTYPE[11:2]) reg_lookup = R_DIST_TYPE;
			if (off[11:2] == OFF_SWSET[11:2]) reg_lookup = R_SWSET;
			if (off[11:2] == OFF_SWCLR[11:2]) reg_lookup = R_SWCLR;
			if (off[11:4] == OFF_PRIO[11:4]) reg_lookup = R_PRIO;
			if (off[11:4] == OFF_TARGET[11:4]) reg_lookup = R_TARGET;
			if (off[11:3] == OFF_W64[11:3]) reg_lookup = R_DIST_W64;
			if (off[11:3] == OFF_W64ONLY[11:3]) reg_lookup = R_DIST_W64ONLY;
			if (off[11:2] == OFF_DB_NS_SET[11:2]) reg_lookup = R_DB_NS_SET;
			if (off[11:2] == OFF_DB_NS_CLR[11:2]) reg_lookup = R_DB_NS_CLR;
			if (off[11:2] == OFF_DB_S_SET[11:2]) reg_lookup = R_DB_S_SET;
			if (off[11:2] == OFF_DB_S_CLR[11:2]) reg_lookup = R_DB_S_CLR;
		end
		GRP_ITS: begin
			if (off[11:3] == OFF_ITS_BASE[11:3]) reg_lookup = R_ITS_BASE;
			if (off[11:2] == OFF_ITS_DB[11:2]) reg_lookup = R_ITS_DB;
		end
		GRP_RDIST: begin
			if (off[11:3] == OFF_W64[11:3]) reg_lookup = R_RDIST_W64;
			if (off[11:4] == OFF_PRIO[11:4]) reg_lookup = R_RPRIO;
		end
		default: reg_lookup = R_NONE;
		endcase
	endfunction

	function automatic ima_kind_t reg_kind(input ima_reg_t r);
		case (r)
		R_CPU_CTL, R_CPU_PMK, R_CPU_BPT, R_CPU_ABPT, R_CPU_AP0, R_CPU_AP1NS,
		R_VIRT_PMK, R_HYP_CTL, R_DIST_CTL, R_DIST_TYPE: reg_kind = K_W32;
		R_SWSET, R_SWCLR, R_PRIO, R_RPRIO, R_TARGET: reg_kind = K_BYTEARR;
		R_DIST_W64, R_ITS_BASE, R_RDIST_W64: reg_kind = K_W64;
		R_DIST_W64ONLY: reg_kind = K_W64ONLY;
		R_DB_NS_SET, R_DB_NS_CLR, R_DB_S_SET, R_DB_S_CLR, R_ITS_DB: reg_kind = K_DOORBELL;
		default: reg_kind = K_NONE;
		endcase
	endfunction

	function automatic ima_acc_t reg_acc(input ima_reg_t r);
		case (reg_kind(r))
		K_DOORBELL: reg_acc = ACC_WO;
		default: reg_acc = (r == R_DIST_TYPE) ? ACC_RO : ACC_RW;
		endcase
	endfunction

endpackage

/* hdl/ima_decode.sv */
/*
 * Access classifier: names the register an access hits and decides whether
 * its size, alignment and kind are supported.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/100ps

module ima_decode
	import ima_pkg::*;
(
	input  wire logic [3:0]  grp,
	input  wire logic [11:0] off,
	input  wire ima_size_t   size,
	input  wire logic        excl,
	input  wire logic        aa32_present,
	output ima_reg_t         reg_id,
	output logic             acc_ok
);

	logic      aligned;
	ima_kind_t kind;

	always_comb begin
		reg_id = reg_lookup(grp, off);
		kind   = reg_kind(reg_id);
		case (size)
		SZ_BYTE:  aligned = 1'b1;
		SZ_HALF:  aligned = (off[0] == 1'b0);
		SZ_WORD:  aligned = (off[1:0] == 2'h0);
		SZ_DWORD: aligned = (off[2:0] == 3'h0);
		default:  aligned = 1'b0;
		endcase
	end

	always_comb begin
		acc_ok = 1'b0;
		case (kind)
		K_W32:      acc_ok = (size == SZ_WORD); // see [R1]
		K_W64:      acc_ok = (size == SZ_DWORD) || (aa32_present && size == SZ_WORD); // see [R2] see [R4]
		K_W64ONLY:  acc_ok = (size == SZ_DWORD); // see [R8]
		K_BYTEARR:  acc_ok = (size == SZ_BYTE) || (size == SZ_WORD); // see [R3]
		K_DOORBELL: acc_ok = (size == SZ_HALF) || (size == SZ_WORD); // see [R5]
		default:    acc_ok = 1'b0;
		endcase
		// misaligned, exclusive and quadword never pass
		if (!aligned || excl || size == SZ_QUAD)
			acc_ok = 1'b0; // see [R7] see [R8]
	end

endmodule

/* hdl/ima_mmio.sv */
/*
 * Memory-mapped register front end of the interrupt controller: size and
 * alignment policing, little-endian lanes, shared priority state with the
 * system-register view and gating by the system-register enables.
 * Assumes one master on a plain strobe port, data in the cycle after a read.
 */
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps

// Functional notes
// [R1] every 32-bit register access is one atomic word operation
// [R2] 64-bit registers of distributor, redistributor, translation take atomic doubleword access
// [R3] byte access only to priority, target and software pending arrays
// [R4] with 32-bit processors, halves of 64-bit registers are word-accessible
// [R5] doorbells accept 16-bit and 32-bit accesses only
// [R6] bytes inside a register follow little-endian order
// [R7] misaligned word and doubleword accesses are unsupported
// [R8] word to 64-bit-only, unlisted doubleword, quadword and exclusive are unsupported
// [R9] unsupported access: read data undefined, write ignored or corrupts
// [R10] accesses complete strictly in arrival order
// [R11] master issues only single-register accesses to strongly ordered memory
// [R12] master confirms write completion, for example by reading back
// [R13] read-only writes ignored, write-only reads undefined, read-write both ways
// [R14] priority mask, active priorities, binary points share storage with system view
// [R15] switching the sharing requirement makes shared contents undefined
// [R16] priority bits and minimum binary point identical in both views
// [R17] a set enable bit may disable or zero its memory-mapped group
// [R18] virtual CPU group stays implemented when its enable is programmable
// [R19] software sets the secure enable bit under a 32-bit top level
// [R20] forbidden memory-mapped accesses may be detected and reported
// [R21] unsupported accesses read zero, write nothing and answer an error
module ima_mmio
	import ima_pkg::*;
#(
	parameter int          PRIO_BITS   = 5,
	parameter logic [2:0]  MIN_BPT     = 3'h0,
	parameter logic [31:0] DIST_TYPE   = 32'h0000_0000,
	parameter bit          BLOCK_RAZWI = 1'b1
)(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	input  wire ima_size_t         size,
	input  wire logic              excl,
	input  wire logic              aa32_present,
	input  wire logic              share_required,
	input  wire logic              sie_sec,
	input  wire logic              sie_hyp,
	input  wire logic              sie_ns,
	input  wire logic              sr_wr,
	input  wire logic              sr_rd,
	input  wire logic [2:0]        sr_sel,
	input  wire logic [31:0]       sr_wdata,
	output logic [DATA_W-1:0]      rdata,
	output logic                   resp_err,
	output logic                   forbidden_access,
	output logic [4:0]             db_valid,
	output logic [31:0]            db_data,
	output logic [31:0]            sr_rdata
);

	localparam logic [7:0] PRIO_MASK = 8'(8'hFF << (8 - PRIO_BITS));

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] shr_reg [2][SH_N];
	logic        share_d_reg;
	logic [31:0] virt_pmk_reg;
	logic [31:0] hyp_ctl_reg;
	logic [31:0] dist_ctl_reg;
	logic [31:0] sw_pend_reg;
	logic [7:0]  prio_reg [2][16];
	logic [7:0]  target_reg [16];
	logic [63:0] w64_reg [4];
	logic [DATA_W-1:0] rdata_reg;
	logic        err_reg;
	logic        forbid_reg;
	logic [4:0]  db_valid_reg;
	logic [31:0] db_data_reg;
	logic [31:0] sr_rdata_reg;

	ima_reg_t    reg_id;
	logic        acc_ok;
	logic        blocked;
	logic [7:0]  be;
	logic [63:0] bm;
	logic [63:0] slot;
	logic [63:0] wv;
	logic [31:0] wword;
	logic        wr_hit;
	logic        rd_hit;
	logic        sr_bank;
	logic [1:0]  w64_idx;
	logic        prio_sel;

	ima_decode u_decode (
		.grp          (addr[15:12]),
		.off          (addr[11:0]),
		.size         (size),
		.excl         (excl),
		.aa32_present (aa32_present),
		.reg_id       (reg_id),
		.acc_ok       (acc_ok)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] size_be(input ima_size_t s, input logic [2:0] a);
		case (s)
		SZ_BYTE:  size_be = 8'(8'h01 << a);
		SZ_HALF:  size_be = 8'(8'h03 << a);
		SZ_WORD:  size_be = 8'(8'h0F << a);
		SZ_DWORD: size_be = 8'hFF;
		default:  size_be = 8'h00;
		endcase
	endfunction

	// implemented bits are the same whichever view writes them
	function automatic logic [31:0] sh_clean(input int idx, input logic [31:0] v);
		case (idx)
		SH_CTL:          sh_clean = {31'h0, v[CTL_CBPT_BIT]};
		SH_PMK:          sh_clean = {24'h0, v[7:0] & PRIO_MASK}; // see [R16]
		SH_BPT, SH_ABPT: sh_clean = {29'h0, (v[BPT_W-1:0] < MIN_BPT) ? MIN_BPT : v[BPT_W-1:0]}; // see [R16]
		default:         sh_clean = v;
		endcase
	endfunction

	function automatic int sh_of(input ima_reg_t r);
		case (r)
		R_CPU_PMK:   sh_of = SH_PMK;
		R_CPU_BPT:   sh_of = SH_BPT;
		R_CPU_ABPT:  sh_of = SH_ABPT;
		R_CPU_AP0:   sh_of = SH_AP0;
		R_CPU_AP1NS: sh_of = SH_AP1NS;
		default:     sh_of = SH_CTL;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// access qualification and lanes
	// ----------------------------------------------------------------
	always_comb begin
		blocked = (addr[15:12] == GRP_CPU && sie_sec) || (addr[15:12] == GRP_HYP && sie_hyp) ||
			(addr[15:12] == GRP_VIRT && sie_ns); // see [R17] see [R18]
		be = size_be(size, addr[2:0]);
		for (int k = 0; k < 8; k++)
			bm[8*k +: 8] = {8{be[k]}};
		wr_hit   = wr_stb && acc_ok && !blocked; // see [R21]
		rd_hit   = rd_stb && acc_ok && !blocked;
		w64_idx  = (reg_id == R_DIST_W64) ? 2'h0 : (reg_id == R_DIST_W64ONLY) ? 2'h1 :
			(reg_id == R_ITS_BASE) ? 2'h2 : 2'h3;
		prio_sel = (reg_id == R_RPRIO);
	end

	// byte k of the slot is the byte at address (addr & ~7) + k
	always_comb begin
		slot = 64'h0;
		case (reg_id)
		R_CPU_CTL, R_CPU_PMK, R_CPU_BPT, R_CPU_ABPT, R_CPU_AP0, R_CPU_AP1NS:
			slot = {2{shr_reg[0][sh_of(reg_id)]}};
		R_VIRT_PMK:  slot = {2{virt_pmk_reg}};
		R_HYP_CTL:   slot = {2{hyp_ctl_reg}};
		R_DIST_CTL:  slot = {2{dist_ctl_reg}};
		R_DIST_TYPE: slot = {2{DIST_TYPE}};
		R_SWSET, R_SWCLR: slot = {2{sw_pend_reg}};
		R_PRIO, R_RPRIO, R_TARGET: begin
			for (int k = 0; k < 8; k++)
				slot[8*k +: 8] = (reg_id == R_TARGET) ? target_reg[{addr[3], 3'(k)}] :
					prio_reg[prio_sel][{addr[3], 3'(k)}]; // see [R6]
		end
		R_DIST_W64, R_DIST_W64ONLY, R_ITS_BASE, R_RDIST_W64: slot = w64_reg[w64_idx];
		default:     slot = 64'h0; // write-only doorbells read as zero, see [R13]
		endcase
		wv    = (slot & ~bm) | (wdata & bm); // see [R6]
		wword = addr[2] ? wv[63:32] : wv[31:0];
	end

	// ----------------------------------------------------------------
	// shared priority state, memory-mapped side bank 0
	// ----------------------------------------------------------------
	// with the common binary point set the secure binary points leave the shared storage
	always_comb begin
		sr_bank = !share_required || (shr_reg[0][SH_CTL][CTL_CBPT_BIT] &&
			(int'(sr_sel) == SH_BPT || int'(sr_sel) == SH_ABPT)); // see [R14]
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			share_d_reg <= 1'b0;
			for (int b = 0; b < 2; b++)
				for (int i = 0; i < SH_N; i++)
					shr_reg[b][i] <= RST_WORD;
		end else begin
			share_d_reg <= share_required;
			if (share_required != share_d_reg) begin
				// the contents are undefined here; clearing keeps them deterministic
				for (int b = 0; b < 2; b++)
					for (int i = 0; i < SH_N; i++)
						shr_reg[b][i] <= RST_WORD; // see [R15]
			end else begin
				if (sr_wr && int'(sr_sel) < SH_N)
					shr_reg[sr_bank][sr_sel] <= sh_clean(int'(sr_sel), sr_wdata); // see [R14]
				// the bus write lands last so it wins a same-cycle collision
				if (wr_hit && addr[15:12] == GRP_CPU)
					shr_reg[0][sh_of(reg_id)] <= sh_clean(sh_of(reg_id), wword); // see [R1]
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sr_rdata_reg <= RST_WORD;
		else if (sr_rd && int'(sr_sel) < SH_N)
			sr_rdata_reg <= shr_reg[sr_bank][sr_sel];
		else
			sr_rdata_reg <= RST_WORD;
	end

	// ----------------------------------------------------------------
	// plain 32-bit registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			virt_pmk_reg <= RST_WORD;
			hyp_ctl_reg  <= RST_WORD;
			dist_ctl_reg <= RST_WORD;
		end else if (wr_hit) begin
			case (reg_id)
			R_VIRT_PMK: virt_pmk_reg <= {24'h0, wword[7:0] & PRIO_MASK}; // see [R16]
			R_HYP_CTL:  hyp_ctl_reg  <= wword; // see [R1]
			R_DIST_CTL: dist_ctl_reg <= wword;
			default:    ; // read-only type register ignores writes, see [R13]
			endcase
		end
	end

	// ----------------------------------------------------------------
	// software interrupt pending, byte-writable set and clear views
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sw_pend_reg <= RST_WORD;
		else if (wr_hit && reg_id == R_SWSET)
			sw_pend_reg <= sw_pend_reg | (addr[2] ? wdata[63:32] & bm[63:32] : wdata[31:0] & bm[31:0]); // see [R3]
		else if (wr_hit && reg_id == R_SWCLR)
			sw_pend_reg <= sw_pend_reg & ~(addr[2] ? wdata[63:32] & bm[63:32] : wdata[31:0] & bm[31:0]);
	end

	// ----------------------------------------------------------------
	// priority and target byte arrays
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 16; i++) begin
				prio_reg[0][i] <= RST_BYTE;
				prio_reg[1][i] <= RST_BYTE;
				target_reg[i]  <= RST_BYTE;
			end
		end else if (wr_hit) begin
			for (int k = 0; k < 8; k++) begin
				if (be[k] && (reg_id == R_PRIO || reg_id == R_RPRIO))
					prio_reg[prio_sel][{addr[3], 3'(k)}] <= wdata[8*k +: 8] & PRIO_MASK; // see [R3] see [R6]
				if (be[k] && reg_id == R_TARGET)
					target_reg[{addr[3], 3'(k)}] <= wdata[8*k +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// 64-bit registers, whole or by halves
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 4; i++)
				w64_reg[i] <= RST_DWORD;
		end else if (wr_hit && (reg_kind(reg_id) == K_W64 || reg_kind(reg_id) == K_W64ONLY)) begin
			w64_reg[w64_idx] <= wv; // see [R2] see [R4]
		end
	end

	// ----------------------------------------------------------------
	// doorbells: one-cycle pulse with the written value
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			db_valid_reg <= 5'h00;
			db_data_reg  <= RST_WORD;
		end else begin
			db_valid_reg <= 5'h00;
			if (wr_hit && reg_kind(reg_id) == K_DOORBELL) begin
				db_data_reg <= addr[2] ? wdata[63:32] & bm[63:32] : wdata[31:0] & bm[31:0]; // see [R5]
				case (reg_id)
				R_DB_NS_SET: db_valid_reg <= 5'h01;
				R_DB_NS_CLR: db_valid_reg <= 5'h02;
				R_DB_S_SET:  db_valid_reg <= 5'h04;
				R_DB_S_CLR:  db_valid_reg <= 5'h08;
				default:     db_valid_reg <= 5'h10;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// response: every strobe answered in the next cycle, in order
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg  <= 64'h0;
			err_reg    <= 1'b0;
			forbid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rd_hit ? slot & bm : 64'h0; // see [R9] see [R10] see [R21]
			err_reg    <= (rd_stb || wr_stb) && (!acc_ok || (blocked && !BLOCK_RAZWI)); // see [R21] see [R17]
			forbid_reg <= (rd_stb || wr_stb) && blocked; // see [R20]
		end
	end

	assign rdata            = rdata_reg;
	assign resp_err         = err_reg;
	assign forbidden_access = forbid_reg;
	assign db_valid         = db_valid_reg;
	assign db_data          = db_data_reg;
	assign sr_rdata         = sr_rdata_reg;

endmodule

/* tb/ima_mmio_properties.sv */
/*
 * Checker for the memory-mapped front end; watches top-level ports only.
 * Assumes BLOCK_RAZWI keeps its default, so supported accesses to blocked groups answer without error.
 */
`timescale 1ns/100ps

module ima_mmio_chk
	import ima_pkg::*;
(
	input wire logic              clock,
	input wire logic              arst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire ima_size_t         size,
	input wire logic              excl,
	input wire logic              sie_sec,
	input wire logic              sie_hyp,
	input wire logic              sie_ns,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              resp_err,
	input wire logic              forbidden_access,
	input wire logic [4:0]        db_valid
);
	logic blk;
	logic stb;
	assign stb = wr_stb || rd_stb;
	assign blk = (addr[15:12] == GRP_CPU && sie_sec) || (addr[15:12] == GRP_HYP && sie_hyp)
		|| (addr[15:12] == GRP_VIRT && sie_ns);

	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_req;
		stb && !blk;
	endsequence

	quad_refused_a: assert property (s_req ##0 size == SZ_QUAD |=> resp_err)
		else $error("quadword access not refused");
	excl_refused_a: assert property (s_req ##0 excl |=> resp_err)
		else $error("exclusive access not refused");
	misalign_word_a: assert property (s_req ##0 (size == SZ_WORD && addr[1:0] != 2'h0) |=> resp_err)
		else $error("misaligned word not refused");
	cpu_byte_a: assert property (s_req ##0 (size == SZ_BYTE && addr[15:12] == GRP_CPU) |=> resp_err)
		else $error("byte access to cpu group not refused");
	db_dword_a: assert property (s_req ##0 (addr[15:4] == 12'h240 && size == SZ_DWORD)
		|=> resp_err && db_valid == 5'h00)
		else $error("doubleword doorbell access accepted");
	err_zero_a: assert property (resp_err |-> rdata == 64'h0)
		else $error("refused access returned data");
	blocked_razwi_a: assert property (stb && blk |=> forbidden_access && !resp_err && rdata == 64'h0)
		else $error("blocked group access not read-as-zero");
	idle_quiet_a: assert property (!stb |=> !resp_err && !forbidden_access && db_valid == 5'h00)
		else $error("answer without a request");
	db_onehot_a: assert property (db_valid != 5'h00 |-> $onehot(db_valid) && $past(wr_stb))
		else $error("doorbell pulse malformed");
endmodule

/* tb/ima_cpu_model.sv */
/*
 * Processor-side master: single-register loads and stores on the strobe port.
 * Assumes the slave answers in the cycle after each strobe, never stalling.
 */
`timescale 1ns/100ps

module ima_cpu_model
	import ima_pkg::*;
(
	input  wire logic              clock,
	output logic [ADDR_W-1:0]      addr,
	output logic [DATA_W-1:0]      wdata,
	output logic                   wr_stb,
	output logic                   rd_stb,
	output ima_size_t              size,
	output logic                   excl,
	input  wire logic [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] got;
	initial begin
		{addr, wdata, wr_stb, rd_stb, excl, got} = '0;
		size = SZ_WORD;
	end
	// one register per access, never merged into wider bursts
	task automatic acc(input logic w, input logic [15:0] a, input logic [63:0] d,
		input ima_size_t s, input logic x);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		size <= s;
		excl <= x;
		wr_stb <= w;
		rd_stb <= !w;
		@(posedge clock);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		// released lines show garbage so stale values cannot pass
		addr <= ~a;
		wdata <= ~d;
		#1 got = rdata;
	endtask
endmodule

/* tb/intc_mmio_access_rules_tb.sv */
/*
 * Testbench of the memory-mapped front end: random data, hand-picked corners.
 * Assumes the default parameters, so priority bytes keep their top five bits.
 */
`timescale 1ns/100ps

module intc_mmio_access_rules_tb
	import ima_pkg::*;
;
	logic clock, arst_n, wr_stb, rd_stb, excl, aa32, share, sie_sec, sie_hyp, sie_ns, sr_wr, sr_rd;
	logic [15:0] addr, a;
	logic [63:0] wdata, rdata, d;
	logic [31:0] sr_wdata, db_data, sr_rdata, v;
	logic [2:0] sr_sel;
	logic [4:0] db_valid;
	logic resp_err, fa;
	logic [7:0] b;
	ima_size_t size;
	int err_total, num_checks;
	logic [15:0] ta[5] = '{16'h2002, 16'h2304, 16'h2300, 16'h2000, 16'h2FF0};
	ima_size_t ts[5] = '{SZ_WORD, SZ_DWORD, SZ_QUAD, SZ_WORD, SZ_WORD};

	ima_mmio dut_u (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .size(size), .excl(excl), .aa32_present(aa32), .share_required(share),
		.sie_sec(sie_sec), .sie_hyp(sie_hyp), .sie_ns(sie_ns), .sr_wr(sr_wr), .sr_rd(sr_rd),
		.sr_sel(sr_sel), .sr_wdata(sr_wdata), .rdata(rdata), .resp_err(resp_err),
		.forbidden_access(fa), .db_valid(db_valid), .db_data(db_data), .sr_rdata(sr_rdata));
	ima_cpu_model cpu_u (.clock(clock), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .size(size), .excl(excl), .rdata(rdata));

	task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic rw(input logic w, input logic [15:0] ad, input logic [63:0] dt,
		input ima_size_t s, input logic e);
		cpu_u.acc(w, ad, dt, s, 1'b0);
		chk("resp_err", 64'(resp_err), 64'(e));
	endtask
	task automatic rdback(input logic [15:0] ad, input ima_size_t s, input logic [63:0] e);
		rw(1'b0, ad, '0, s, 1'b0);
		chk("rdata", cpu_u.got, e);
	endtask

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		report_and_stop();
	end
	initial begin
		{arst_n, aa32, sie_sec, sie_hyp, sie_ns, sr_wr, sr_rd, sr_sel, sr_wdata} = '0;
		share = 1'b1;
		err_total = 0;
		num_checks = 0;
		void'($urandom(32'hB569A65A));
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		rdback(16'h2000, SZ_WORD, 64'h0);
		v = $urandom();
		rw(1'b1, 16'h2000, 64'(v), SZ_WORD, 1'b0);
		rdback(16'h2000, SZ_WORD, 64'(v));
		d = {$urandom(), $urandom()};
		rw(1'b1, 16'h2300, d, SZ_DWORD, 1'b0);
		rdback(16'h2300, SZ_DWORD, d);
		rw(1'b0, 16'h2304, '0, SZ_WORD, 1'b1);
		aa32 <= 1'b1;
		rdback(16'h2304, SZ_WORD, {d[63:32], 32'h0});
		rw(1'b1, 16'h2304, {v, 32'h0}, SZ_WORD, 1'b0);
		rdback(16'h2300, SZ_DWORD, {v, d[31:0]});
		rw(1'b0, 16'h2308, '0, SZ_WORD, 1'b1);
		b = 8'($urandom());
		rw(1'b1, 16'h2101, 64'(b) << 8, SZ_BYTE, 1'b0);
		rdback(16'h2101, SZ_BYTE, 64'(b & 8'hF8) << 8);
		rw(1'b1, 16'h2001, '1, SZ_BYTE, 1'b1);
		rw(1'b1, 16'h0004, '1, SZ_BYTE, 1'b1);
		rw(1'b1, 16'h2042, 64'(b) << 16, SZ_BYTE, 1'b0);
		rw(1'b1, 16'h2046, 64'h000F_0000_0000_0000, SZ_BYTE, 1'b0);
		rdback(16'h2040, SZ_WORD, 64'(b & 8'hF0) << 16);
		for (int i = 0; i < 5; i++) begin
			cpu_u.acc(i[0], ta[i], '1, ts[i], i == 3);
			chk("resp_err", 64'(resp_err), 64'h1);
			chk("rdata", cpu_u.got, 64'h0);
		end
		rdback(16'h2000, SZ_WORD, 64'(v));
		rw(1'b1, 16'h2004, '1, SZ_WORD, 1'b0);
		rdback(16'h2004, SZ_WORD, 64'h0);
		for (int i = 0; i < 5; i++) begin
			a = (i < 4) ? 16'h2400 + 16'(4 * i) : 16'h4040;
			v = $urandom();
			cpu_u.acc(1'b1, a, 64'(v[15:0]) << (8 * a[2:0]), SZ_HALF, 1'b0);
			chk("db_valid", 64'(db_valid), 64'(5'h01 << i));
			chk("db_data", 64'(db_data), 64'(v[15:0]));
		end
		rw(1'b1, 16'h2400, '1, SZ_DWORD, 1'b1);
		rdback(16'h2408, SZ_WORD, 64'h0);
		rw(1'b1, 16'h1004, 64'h0000_00F8_0000_0000, SZ_WORD, 1'b0);
		rdback(16'h1004, SZ_WORD, 64'h0000_00F8_0000_0000);
		v = $urandom();
		@(posedge clock);
		sr_sel <= 3'h4;
		sr_wdata <= v;
		sr_wr <= 1'b1;
		@(posedge clock);
		sr_wr <= 1'b0;
		rdback(16'h0010, SZ_WORD, 64'(v));
		@(posedge clock);
		sr_rd <= 1'b1;
		@(posedge clock);
		sr_rd <= 1'b0;
		#1 chk("sr_rdata", 64'(sr_rdata), 64'(v));
		share <= 1'b0;
		repeat (2) @(posedge clock);
		rdback(16'h0010, SZ_WORD, 64'h0);
		sie_sec <= 1'b1;
		cpu_u.acc(1'b0, 16'h0000, '0, SZ_WORD, 1'b0);
		chk("forbidden", 64'(fa), 64'h1);
		chk("rdata", cpu_u.got, 64'h0);
		report_and_stop();
	end
endmodule

bind ima_mmio ima_mmio_chk chk_u (.clock(clock), .arst_n(arst_n), .addr(addr), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .size(size), .excl(excl), .sie_sec(sie_sec), .sie_hyp(sie_hyp),
	.sie_ns(sie_ns), .rdata(rdata), .resp_err(resp_err), .forbidden_access(forbidden_access),
	.db_valid(db_valid));
